/* logic/ldi_pkg.sv */
// Purpose: Shared constants and carrier types for the status lamp driver.
// Assumes: APB register access, 32-bit data, one aligned word per register.
// Notes:   Timing defaults are counts of pclk cycles at 200 MHz.

package ldi_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;   // Mode and test control
    localparam logic [11:0] ADDR_STATUS = 12'h004; // Latched channel state
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // All CAN, no test
    localparam int CTRL_LIN_POS = 0;               // One LIN bit per channel
    localparam int CTRL_RUN_POS = 8;               // Running pattern enable
    localparam int STAT_OVR_POS = 0;               // Overrun latch per channel
    localparam int STAT_REF_POS = 8;               // Reference voltage per channel

    // ----------------------------------------------------------------
    // Pattern timing, in pclk cycles
    // ----------------------------------------------------------------
    localparam int FLASH_CYCLES_DEF = 10_000_000;  // 50 ms flash
    localparam int SLOW_HALF_DEF = 100_000_000;    // 0.5 s slow half period
    localparam int FAST_HALF_DEF = 25_000_000;     // 125 ms fast half period
    localparam int RUN_STEP_DEF = 40_000_000;      // 200 ms per running step

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    // Status events from one channel's bus controller
    typedef struct packed {
        logic msg;        // Message sent or received, one cycle
        logic err_frame;  // Error frame received, one cycle
        logic err_passive; // Error-passive level
        logic overrun;    // Overrun, one cycle
        logic bus_off;    // Bus-off level
    } ldi_chan_evt_type;

    // One dual-colour lamp: col_a is the first colour, col_b the second
    typedef struct packed {
        logic col_a;
        logic col_b;
    } ldi_lamp_type;

endpackage

/* logic/ldi_status_lamps.sv */
// Purpose: Drives supply, port activity and mode lamps of a two-channel unit.
// Assumes: Event inputs come from logic on pclk; reference pins are async.
// Notes:   Supply lamp green/yellow, port lamps yellow/red, mode lamps
//          green/yellow. Registers over APB, zero wait states.
//
// Local design decisions: the APB slave port and the placing of the registers.

`timescale 1ns/100ps

module ldi_status_lamps #(
    parameter int NCH = 2,
    parameter int FLASH_CYCLES = ldi_pkg::FLASH_CYCLES_DEF,
    parameter int SLOW_HALF = ldi_pkg::SLOW_HALF_DEF,
    parameter int FAST_HALF = ldi_pkg::FAST_HALF_DEF,
    parameter int RUN_STEP = ldi_pkg::RUN_STEP_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_configured,
    input wire logic fw_cfg_error,
    input wire logic power_fault,
    input wire logic fw_update,
    input wire logic dev_error,
    input wire ldi_pkg::ldi_chan_evt_type [NCH-1:0] chan_evt,
    input wire logic [NCH-1:0] lin_internal_act,
    input wire logic [NCH-1:0] lin_ref_pin,
    output ldi_pkg::ldi_lamp_type supply_lamp,
    output ldi_pkg::ldi_lamp_type [NCH-1:0] port_activity_lamp,
    output ldi_pkg::ldi_lamp_type [NCH-1:0] mode_lamp
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (NCH < 1 || NCH > 8 || FLASH_CYCLES < 1 || RUN_STEP < 1
        || FAST_HALF < 1 || SLOW_HALF <= FAST_HALF)
    begin : g_bad_param
        $error("ldi_status_lamps: unsupported parameter values");
    end

    localparam logic [4:0] RUN_LAST = 5'(2 * NCH + 1); // Last running step

    // Next value of a free-running wrap counter
    function automatic logic [31:0] wrap_step(input logic [31:0] cnt, input int lim);
        wrap_step = (cnt >= 32'(lim - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
    endfunction

    // ----------------------------------------------------------------
    // Registers and internal state
    // ----------------------------------------------------------------
    logic [NCH-1:0] lin_mode_reg;    // Channel opened as LIN
    logic run_en_reg;                // Running pattern requested
    logic [NCH-1:0] ref_meta_reg;    // Synchroniser first stage
    logic [NCH-1:0] ref_sync_reg;    // Synchronised reference present
    logic [NCH-1:0] ovr_reg;         // Overrun latch per channel
    logic [31:0] slow_cnt_reg;       // Slow half-period counter
    logic [31:0] fast_cnt_reg;       // Fast half-period counter
    logic [31:0] run_cnt_reg;        // Running step counter
    logic slow_ph_reg;               // Slow pattern phase
    logic fast_ph_reg;               // Fast pattern phase
    logic [4:0] run_idx_reg;         // Running pattern position
    logic [31:0] flash_y_reg [NCH];  // Yellow flash remaining
    logic [31:0] flash_r_reg [NCH];  // Red flash remaining
    logic [31:0] rd_val;             // Read mux result
    logic rd_hit;                    // Address is mapped
    logic fault_any;                 // Anything above normal operation
    ldi_pkg::ldi_lamp_type supply_next;
    ldi_pkg::ldi_lamp_type [NCH-1:0] port_next;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; answer comes in the access phase
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;

    // Address decode and read mux
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            ldi_pkg::ADDR_CTRL:
            begin
                rd_val[ldi_pkg::CTRL_LIN_POS +: NCH] = lin_mode_reg;
                rd_val[ldi_pkg::CTRL_RUN_POS] = run_en_reg;
            end
            ldi_pkg::ADDR_STATUS:
            begin
                rd_val[ldi_pkg::STAT_OVR_POS +: NCH] = ovr_reg;
                rd_val[ldi_pkg::STAT_REF_POS +: NCH] = ref_sync_reg;
            end
            default: rd_hit = 1'b0; // Unmapped reads as zero with error
        endcase
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_val;
    end

    // Control register write; the write lands at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lin_mode_reg <= ldi_pkg::CTRL_RESET[ldi_pkg::CTRL_LIN_POS +: NCH];
            run_en_reg <= ldi_pkg::CTRL_RESET[ldi_pkg::CTRL_RUN_POS];
        end
        else if (psel && penable && pwrite && paddr == ldi_pkg::ADDR_CTRL)
        begin
            lin_mode_reg <= pwdata[ldi_pkg::CTRL_LIN_POS +: NCH];
            run_en_reg <= pwdata[ldi_pkg::CTRL_RUN_POS];
        end
    end

    // ----------------------------------------------------------------
    // Reference voltage synchroniser
    // ----------------------------------------------------------------
    // Pins are asynchronous; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_meta_reg <= '0;
            ref_sync_reg <= '0;
        end
        else
        begin
            ref_meta_reg <= lin_ref_pin;
            ref_sync_reg <= ref_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Pattern timebase
    // ----------------------------------------------------------------
    // Phases toggle each half period, so on and off are equal
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_cnt_reg <= 32'h0000_0000;
            fast_cnt_reg <= 32'h0000_0000;
            slow_ph_reg <= 1'b0;
            fast_ph_reg <= 1'b0;
        end
        else
        begin
            slow_cnt_reg <= wrap_step(slow_cnt_reg, SLOW_HALF);
            fast_cnt_reg <= wrap_step(fast_cnt_reg, FAST_HALF);
            if (slow_cnt_reg == 32'(SLOW_HALF - 1))
                slow_ph_reg <= ~slow_ph_reg;
            if (fast_cnt_reg == 32'(FAST_HALF - 1))
                fast_ph_reg <= ~fast_ph_reg;
        end
    end

    // Running pattern stepper; restarts from supply green when enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_cnt_reg <= 32'h0000_0000;
            run_idx_reg <= 5'h00;
        end
        else if (!run_en_reg)
        begin
            run_cnt_reg <= 32'h0000_0000;
            run_idx_reg <= 5'h00;
        end
        else
        begin
            run_cnt_reg <= wrap_step(run_cnt_reg, RUN_STEP);
            if (run_cnt_reg == 32'(RUN_STEP - 1))
                run_idx_reg <= (run_idx_reg == RUN_LAST) ? 5'h00 : run_idx_reg + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Per-channel event capture
    // ----------------------------------------------------------------
    // Overrun latch: set wins over a bus-off clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovr_reg <= '0;
        else
            for (int c = 0; c < NCH; c++)
                if (chan_evt[c].overrun && !lin_mode_reg[c])
                    ovr_reg[c] <= 1'b1;
                else if (chan_evt[c].bus_off)
                    ovr_reg[c] <= 1'b0;
    end

    // Flash counters reload on every event, so a burst reads as steady
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            for (int c = 0; c < NCH; c++)
            begin
                flash_y_reg[c] <= 32'h0000_0000;
                flash_r_reg[c] <= 32'h0000_0000;
            end
        else
            for (int c = 0; c < NCH; c++)
            begin
                if (chan_evt[c].msg || (lin_mode_reg[c] && lin_internal_act[c]))
                    flash_y_reg[c] <= 32'(FLASH_CYCLES);
                else if (flash_y_reg[c] != 32'h0000_0000)
                    flash_y_reg[c] <= flash_y_reg[c] - 32'h0000_0001;
                // Error frames only mean something on a CAN channel
                if (chan_evt[c].err_frame && !lin_mode_reg[c])
                    flash_r_reg[c] <= 32'(FLASH_CYCLES);
                else if (flash_r_reg[c] != 32'h0000_0000)
                    flash_r_reg[c] <= flash_r_reg[c] - 32'h0000_0001;
            end
    end

    // ----------------------------------------------------------------
    // Lamp selection
    // ----------------------------------------------------------------
    assign fault_any = run_en_reg | fw_update | ~usb_configured | fw_cfg_error
        | power_fault | dev_error;

    // Supply lamp: col_a green, col_b yellow
    always_comb
    begin
        supply_next = '{col_a: 1'b1, col_b: 1'b0};
        if (run_en_reg)
            supply_next = '{col_a: run_idx_reg == 5'h00, col_b: run_idx_reg == 5'h01};
        else if (fw_update)
            supply_next = '{col_a: 1'b1, col_b: 1'b0};
        else if (!usb_configured)
            supply_next = '{col_a: 1'b0, col_b: slow_ph_reg};
        else if (fw_cfg_error || power_fault)
            supply_next = '{col_a: ~slow_ph_reg, col_b: slow_ph_reg};
    end

    // Port lamps: col_a yellow, col_b red, highest priority first
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (run_en_reg)
                port_next[c] = '{col_a: run_idx_reg == 5'(2 + 2 * c),
                                 col_b: run_idx_reg == 5'(3 + 2 * c)};
            else if (fw_update)
                port_next[c] = '{col_a: fast_ph_reg, col_b: 1'b0};
            else if (!usb_configured)
                port_next[c] = '{col_a: 1'b0, col_b: 1'b0};
            else if (fw_cfg_error)
                port_next[c] = '{col_a: ~slow_ph_reg, col_b: slow_ph_reg};
            else if (power_fault)
                port_next[c] = '{col_a: slow_ph_reg, col_b: 1'b0};
            else if (dev_error)
                port_next[c] = '{col_a: 1'b0, col_b: 1'b1};
            else if (ovr_reg[c])
                port_next[c] = '{col_a: 1'b0, col_b: 1'b1};
            else if (!lin_mode_reg[c] && chan_evt[c].err_passive)
                port_next[c] = '{col_a: 1'b0, col_b: fast_ph_reg};
            else
                port_next[c] = '{col_a: flash_y_reg[c] != 32'h0000_0000,
                                 col_b: flash_r_reg[c] != 32'h0000_0000};
        end
    end

    // Lamp outputs registered to keep the pins glitch free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            supply_lamp <= '0;
            port_activity_lamp <= '0;
            mode_lamp <= '0;
        end
        else
        begin
            supply_lamp <= supply_next;
            port_activity_lamp <= port_next;
            for (int c = 0; c < NCH; c++)
            begin
                mode_lamp[c].col_a <= ~run_en_reg & lin_mode_reg[c];
                mode_lamp[c].col_b <= ~run_en_reg & ref_sync_reg[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_supply_green;
        !fault_any |=> supply_lamp.col_a && !supply_lamp.col_b;
    endproperty
    a_supply_green: assert property (p_supply_green)
        else $error("supply lamp not steady green");

    property p_unconf;
        !run_en_reg && !fw_update && !usb_configured
            |=> port_activity_lamp == '0 && supply_lamp.col_b == $past(slow_ph_reg);
    endproperty
    a_unconf: assert property (p_unconf)
        else $error("unconfigured pattern wrong");

    property p_fw_update;
        !run_en_reg && fw_update
            |=> port_activity_lamp[0].col_a == $past(fast_ph_reg) && !port_activity_lamp[0].col_b;
    endproperty
    a_fw_update: assert property (p_fw_update)
        else $error("update blink wrong");

    property p_ovr_hold;
        ovr_reg[0] && !chan_evt[0].bus_off |=> ovr_reg[0];
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("overrun latch dropped early");

    property p_flash_len;
        chan_evt[0].msg ##1 !chan_evt[0].msg && !lin_internal_act[0]
            |-> flash_y_reg[0] == 32'(FLASH_CYCLES);
    endproperty
    a_flash_len: assert property (p_flash_len)
        else $error("flash length wrong");

    property p_passive;
        !fault_any && !ovr_reg[0] && !lin_mode_reg[0] && chan_evt[0].err_passive
            |=> port_activity_lamp[0].col_b == $past(fast_ph_reg);
    endproperty
    a_passive: assert property (p_passive)
        else $error("error passive blink wrong");

    property p_mode_lamp;
        ##1 !$past(run_en_reg)
            |-> mode_lamp[0].col_a == $past(lin_mode_reg[0])
                && mode_lamp[0].col_b == $past(ref_sync_reg[0]);
    endproperty
    a_mode_lamp: assert property (p_mode_lamp)
        else $error("mode lamp wrong");

    property p_run_onehot;
        run_en_reg [*2] |-> $onehot({supply_lamp, port_activity_lamp});
    endproperty
    a_run_onehot: assert property (p_run_onehot)
        else $error("running pattern not one lamp at a time");

    property p_dev_error;
        !run_en_reg && !fw_update && usb_configured && !fw_cfg_error && !power_fault
            && dev_error |=> port_activity_lamp[0].col_b && !port_activity_lamp[0].col_a;
    endproperty
    a_dev_error: assert property (p_dev_error)
        else $error("device error red missing");

endmodule

/* tb/ldi_chan_partner.sv */
// Purpose: Stand-in for the channel controllers and host link status.
// Assumes: The bench calls its tasks right after a rising pclk edge.
// Notes:   Pulses last exactly one cycle; levels are set by the bench.
`timescale 1ns/100ps

module ldi_chan_partner (
    input wire logic pclk,
    output ldi_pkg::ldi_chan_evt_type [1:0] chan_evt,
    output logic [1:0] lin_internal_act,
    output logic [1:0] lin_ref_pin,
    output logic usb_configured,
    output logic fw_cfg_error,
    output logic power_fault,
    output logic fw_update,
    output logic dev_error
);
    // ------------------------------------------------------------
    // Quiet state: host link not yet configured
    // ------------------------------------------------------------
    initial
    begin
        chan_evt = '0;
        lin_internal_act = 2'h0;
        lin_ref_pin = 2'h0;
        usb_configured = 1'h0;
        fw_cfg_error = 1'h0;
        power_fault = 1'h0;
        fw_update = 1'h0;
        dev_error = 1'h0;
    end

    // One-cycle event: 0 message, 1 error frame, 2 overrun, else LIN activity
    task automatic pulse(input int ch, input int kind);
        @(posedge pclk);
        case (kind)
            0: chan_evt[ch].msg <= 1'h1;
            1: chan_evt[ch].err_frame <= 1'h1;
            2: chan_evt[ch].overrun <= 1'h1;
            default: lin_internal_act[ch] <= 1'h1;
        endcase
        // Drop every pulse after one edge so none stretches
        @(posedge pclk);
        chan_evt[ch].msg <= 1'h0;
        chan_evt[ch].err_frame <= 1'h0;
        chan_evt[ch].overrun <= 1'h0;
        lin_internal_act[ch] <= 1'h0;
    endtask
endmodule

/* tb/test_ldi_status_lamps.sv */
// Purpose: Self-checking bench for the status lamp driver.
// Assumes: Short pattern parameters; APB answers are awaited, not assumed.
// Notes:   Patterns are judged by lit cycles over whole periods, so the
//          phase of the free-running pattern counters never matters.
`timescale 1ns/100ps

module test_ldi_status_lamps;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam int FL = 4; // Flash length
    localparam int SH = 16; // Slow half period
    localparam int FH = 4; // Fast half period
    localparam logic [63:0] M_SG = 64'h200; // Supply green
    localparam logic [63:0] M_SY = 64'h100; // Supply yellow
    localparam logic [63:0] M_P1Y = 64'h80; // Port lamp 1
    localparam logic [63:0] M_P1R = 64'h40;
    localparam logic [63:0] M_P0Y = 64'h20; // Port lamp 0
    localparam logic [63:0] M_P0R = 64'h10;
    localparam logic [63:0] M_M0G = 64'h2; // Mode lamp 0
    localparam logic [63:0] M_M0Y = 64'h1;
    localparam logic [63:0] M_RD = 64'h7FF_FFFF_FC00; // Error flag and read data
    localparam logic [63:0] M_ERR = 64'h400_0000_0000;
    typedef struct packed {logic [63:0] exp; logic [63:0] mask;} ldi_note_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, ua;
    logic [31:0] pwdata, prdata;
    logic [1:0] lin_internal_act, lin_ref_pin;
    logic usb_configured, fw_cfg_error, power_fault, fw_update, dev_error;
    ldi_pkg::ldi_chan_evt_type [1:0] chan_evt;
    ldi_pkg::ldi_lamp_type supply_lamp;
    ldi_pkg::ldi_lamp_type [1:0] port_activity_lamp, mode_lamp;
    logic [63:0] obs; // Everything the monitor looks at
    ldi_note_type note_q[$]; // Expected results, oldest first
    ldi_note_type cur;
    int fails = 0;
    int samples_checked = 0;
    assign obs = {21'h0, pslverr, prdata, supply_lamp, port_activity_lamp, mode_lamp};

    ldi_status_lamps #(.NCH(2), .FLASH_CYCLES(FL), .SLOW_HALF(SH), .FAST_HALF(FH),
        .RUN_STEP(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usb_configured(usb_configured), .fw_cfg_error(fw_cfg_error),
        .power_fault(power_fault), .fw_update(fw_update), .dev_error(dev_error),
        .chan_evt(chan_evt), .lin_internal_act(lin_internal_act),
        .lin_ref_pin(lin_ref_pin), .supply_lamp(supply_lamp),
        .port_activity_lamp(port_activity_lamp), .mode_lamp(mode_lamp));
    ldi_chan_partner partner_u (.pclk(pclk), .chan_evt(chan_evt),
        .lin_internal_act(lin_internal_act), .lin_ref_pin(lin_ref_pin),
        .usb_configured(usb_configured), .fw_cfg_error(fw_cfg_error),
        .power_fault(power_fault), .fw_update(fw_update), .dev_error(dev_error));

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Monitor: one note per settled mid-cycle sample
    always @(negedge pclk)
    begin
        if (note_q.size() > 0)
        begin
            cur = note_q.pop_front();
            compare(obs & cur.mask, cur.exp & cur.mask);
        end
    end

    // Hang guard; the whole run is far shorter
    initial
    begin
        repeat (30000) @(posedge pclk);
        fails++;
        test_done();
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic wait_c(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Note one snapshot, checked at the next falling edge
    task automatic snap(input logic [63:0] m, input logic [63:0] e);
        note_q.push_back('{exp: e, mask: m});
        @(posedge pclk);
    endtask

    // Count cycles with any masked lamp lit
    task automatic cnt(input logic [63:0] m, input int n, input int e);
        int c;
        c = 0;
        repeat (n)
        begin
            @(negedge pclk);
            if ((obs & m) != 64'h0)
                c++;
        end
        compare(64'(c), 64'(e));
        @(posedge pclk);
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] rd, input logic err);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        note_q.push_back('{exp: {21'h0, err, rd, 10'h0}, mask: wr ? M_ERR : M_RD});
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            test_done();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // Running order: green, yellow, port 0 yellow/red, port 1 yellow/red
    function automatic logic [5:0] nxt(input logic [5:0] p);
        case (p)
            6'h20: nxt = 6'h10;
            6'h10: nxt = 6'h02;
            6'h02: nxt = 6'h01;
            6'h01: nxt = 6'h08;
            6'h08: nxt = 6'h04;
            default: nxt = 6'h20;
        endcase
    endfunction

    task automatic run_order();
        logic [5:0] prev, now;
        int bad;
        prev = 6'h0;
        bad = 0;
        repeat (60)
        begin
            @(negedge pclk);
            now = obs[9:4];
            if ($countones(now) != 1)
                bad++;
            else if (prev != 6'h0 && now != prev && now != nxt(prev))
                bad++;
            prev = now;
        end
        compare(64'(bad), 64'h0);
        @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        void'($urandom(52267));
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        wait_c(3);
        // Host link not configured yet
        cnt(M_SY, 64, 32);
        cnt(M_SG, 64, 0);
        fork
            cnt(M_P0Y | M_P0R | M_P1Y | M_P1R, 20, 0);
            partner_u.pulse(0, 0);
        join
        // Register reset values, unmapped and read-only places
        ua = 12'h008 + 12'(($urandom % 1022) * 4);
        apb(1'h0, ldi_pkg::ADDR_CTRL, 32'h0, ldi_pkg::CTRL_RESET, 1'h0);
        apb(1'h0, ldi_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'h0);
        apb(1'h0, ua, 32'h0, 32'h0, 1'h1);
        apb(1'h1, ua, $urandom, 32'h0, 1'h1);
        apb(1'h1, ldi_pkg::ADDR_STATUS, $urandom, 32'h0, 1'h0);
        apb(1'h0, ldi_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'h0);
        // Configured and idle
        partner_u.usb_configured <= 1'h1;
        wait_c(3);
        cnt(M_SG, 20, 20);
        cnt(M_P0Y | M_P0R | M_P1Y | M_P1R, 20, 0);
        // Flashes, single and back to back
        fork
            cnt(M_P0Y, 20, FL);
            partner_u.pulse(0, 0);
        join
        fork
            cnt(M_P0Y, 24, FL + 2);
            begin
                partner_u.pulse(0, 0);
                partner_u.pulse(0, 0);
            end
        join
        fork
            cnt(M_P1R, 20, FL);
            partner_u.pulse(1, 1);
        join
        // Error passive, then overrun on top, then update on top
        partner_u.chan_evt[0].err_passive <= 1'h1;
        wait_c(3);
        cnt(M_P0R, 32, 16);
        partner_u.pulse(0, 2);
        wait_c(2);
        cnt(M_P0R, 32, 32);
        apb(1'h0, ldi_pkg::ADDR_STATUS, 32'h0, 32'h1, 1'h0);
        partner_u.fw_update <= 1'h1;
        wait_c(3);
        cnt(M_P0Y, 32, 16);
        cnt(M_P1Y, 32, 16);
        cnt(M_P0R, 32, 0);
        partner_u.fw_update <= 1'h0;
        partner_u.chan_evt[0].err_passive <= 1'h0;
        partner_u.chan_evt[0].bus_off <= 1'h1;
        wait_c(3);
        cnt(M_P0R, 20, 0);
        partner_u.chan_evt[0].bus_off <= 1'h0;
        partner_u.dev_error <= 1'h1;
        wait_c(3);
        snap(M_P0R | M_P1R, M_P0R | M_P1R);
        partner_u.dev_error <= 1'h0;
        // Firmware configuration error, then power problem
        partner_u.fw_cfg_error <= 1'h1;
        wait_c(3);
        cnt(M_SG, 64, 32);
        cnt(M_SG | M_SY, 64, 64);
        cnt(M_P0Y, 64, 32);
        cnt(M_P0Y | M_P0R, 64, 64);
        partner_u.fw_cfg_error <= 1'h0;
        partner_u.power_fault <= 1'h1;
        wait_c(3);
        cnt(M_SG | M_SY, 64, 64);
        cnt(M_SY, 64, 32);
        cnt(M_P1Y, 64, 32);
        cnt(M_P1R, 64, 0);
        partner_u.power_fault <= 1'h0;
        // Channel 0 in LIN mode
        apb(1'h1, ldi_pkg::ADDR_CTRL, 32'h1, 32'h0, 1'h0);
        wait_c(2);
        snap(M_M0G, M_M0G);
        fork
            cnt(M_P0Y, 20, FL);
            partner_u.pulse(0, 3);
        join
        // Error frames mean nothing on a LIN channel
        fork
            cnt(M_P0R, 20, 0);
            partner_u.pulse(0, 1);
        join
        partner_u.lin_ref_pin <= 2'h1;
        wait_c(5);
        snap(M_M0G | M_M0Y | 64'hC, M_M0G | M_M0Y);
        apb(1'h0, ldi_pkg::ADDR_STATUS, 32'h0, 32'h100, 1'h0);
        // Running pattern
        apb(1'h1, ldi_pkg::ADDR_CTRL, 32'h100, 32'h0, 1'h0);
        wait_c(3);
        run_order();
        cnt(M_SG, 48, 8);
        apb(1'h1, ldi_pkg::ADDR_CTRL, 32'h0, 32'h0, 1'h0);
        wait_c(4);
        test_done();
    end
endmodule
